// File: logic/acs_pkg.sv
// What this block does
// - power enable at one powers the converter; conversions need it set
// - an internal source disconnects the external channel input automatically
// - alignment bit arranges the result across high and low result bytes
// - interrupt reaches the cpu only with global and converter enables both set
// - start low-high-low runs one conversion: high resets, falling edge launches
// - busy reads high during conversion, low at completion, then result is readable
// - power enable cleared means the converter circuitry draws no power
// - result is 12-bit unsigned, full scale gives all ones
// - one code step equals reference divided by 4096
// - the interrupt request flag clears when software writes a zero to it
// - conversion takes 4 sampling plus 12 conversion periods, 16 in total
// - three-bit divider selects system clock over 2 to the field value
// - completion sets the interrupt request flag
package acs_pkg;

  localparam int unsigned RES_BITS     = 12;
  localparam int unsigned SAMPLE_TICKS = 4;
  localparam int unsigned CONV_TICKS   = 12;
  localparam int unsigned FULL_CODES   = 4096;

  // byte addresses on the register bus
  localparam logic [7:0] OFS_CTRL0  = 8'h00;
  localparam logic [7:0] OFS_CTRL1  = 8'h04;
  localparam logic [7:0] OFS_CTRL2  = 8'h08;
  localparam logic [7:0] OFS_RES_HI = 8'h0c;
  localparam logic [7:0] OFS_RES_LO = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_MASK   = 8'h18;
  localparam logic [7:0] OFS_GIE    = 8'h1c;

  // conv_control_0 fields
  localparam int unsigned C0_START = 7;
  localparam int unsigned C0_BUSY  = 6;
  localparam int unsigned C0_PWR   = 5;
  localparam int unsigned C0_ALIGN = 4;
  localparam int unsigned C0_CH_LO = 0;
  // conv_control_1 fields
  localparam int unsigned C1_SRC_LO = 4;
  localparam int unsigned C1_DIV_LO = 0;
  // conv_control_2 fields
  localparam int unsigned C2_REF_LO = 0;
  // status / mask / global enable
  localparam int unsigned IRQ_DONE = 0;

  localparam logic [3:0] SRC_EXTERNAL = 4'h0;

  localparam logic [3:0] RST_CHANNEL = 4'h0;
  localparam logic [3:0] RST_SOURCE  = 4'h0;
  localparam logic [2:0] RST_DIV     = 3'h0;
  localparam logic [1:0] RST_REF     = 2'h0;
  localparam logic [3:0] RST_PHASE   = 4'h0;
  localparam logic [6:0] RST_DIVCNT  = 7'h00;
  localparam logic [RES_BITS-1:0] RST_RESULT = 12'h000;
  localparam logic [RES_BITS-1:0] TRIAL_MSB  = 12'h800;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b11,
    ST_DONE    = 2'b10
  } acs_state_e;

  typedef struct packed {
    logic [3:0] ext_channel_sel;
    logic       result_align_sel;
    logic       converter_power_en;
    logic [3:0] input_source_sel;
    logic [2:0] conv_clock_div;
    logic [1:0] ref_source_sel;
  } acs_cfg_s;

  typedef struct packed {
    logic                converter_power_en;
    logic                sample;
    logic                ext_connect;
    logic [3:0]          ext_channel_sel;
    logic [3:0]          input_source_sel;
    logic [1:0]          ref_source_sel;
    logic [RES_BITS-1:0] trial_code;
  } acs_analog_s;

endpackage

// File: logic/acs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer
  import acs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        comp_i,
  output acs_analog_s      analog_o,
  output logic             irq_o
);

  // divider limit: system clock over 2**div
  function automatic logic [6:0] div_limit(input logic [2:0] div);
    logic [7:0] span;
    span = 8'h01 << div;
    return 7'(span - 8'h01);
  endfunction

  function automatic logic [7:0] res_high(input logic [RES_BITS-1:0] r, input logic align);
    return align ? {4'h0, r[11:8]} : r[11:4];
  endfunction

  function automatic logic [7:0] res_low(input logic [RES_BITS-1:0] r, input logic align);
    return align ? r[7:0] : {r[3:0], 4'h0};
  endfunction

  // comparator crosses from the analog side, two flops before use
  logic comp_meta_q;
  logic comp_sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comp_meta_q <= 1'b0;
      comp_sync_q <= 1'b0;
    end else begin
      comp_meta_q <= comp_i;
      comp_sync_q <= comp_meta_q;
    end
  end

  // register bus
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic        bus_req;
  logic        wr_en;

  acs_cfg_s    cfg_q;
  acs_cfg_s    cfg_d;
  logic        start_q;
  logic        start_d;
  logic        flag_q;
  logic        flag_d;
  logic        mask_q;
  logic        mask_d;
  logic        gie_q;
  logic        gie_d;

  acs_state_e          state_q;
  acs_state_e          state_d;
  logic [3:0]          phase_q;
  logic [3:0]          phase_d;
  logic [6:0]          divcnt_q;
  logic [6:0]          divcnt_d;
  logic [RES_BITS-1:0] sar_q;
  logic [RES_BITS-1:0] sar_d;
  logic [RES_BITS-1:0] bit_q;
  logic [RES_BITS-1:0] bit_d;
  logic [RES_BITS-1:0] result_q;
  logic [RES_BITS-1:0] result_d;

  logic busy;
  logic tick;
  logic start_fall;
  logic done_evt;

  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_en   = bus_req & wb_we_i & wb_sel_i[0];
  assign busy    = (state_q == ST_SAMPLE) || (state_q == ST_CONVERT);

  always_comb begin
    ack_d  = bus_req;
    rdat_d = rdat_q;
    if (bus_req && !wb_we_i) begin
      rdat_d = 32'h0000_0000;
      if (wb_adr_i == OFS_CTRL0) begin
        rdat_d[C0_START]         = start_q;
        rdat_d[C0_BUSY]          = busy;
        rdat_d[C0_PWR]           = cfg_q.converter_power_en;
        rdat_d[C0_ALIGN]         = cfg_q.result_align_sel;
        rdat_d[C0_CH_LO +: 4]    = cfg_q.ext_channel_sel;
      end else if (wb_adr_i == OFS_CTRL1) begin
        rdat_d[C1_SRC_LO +: 4]   = cfg_q.input_source_sel;
        rdat_d[C1_DIV_LO +: 3]   = cfg_q.conv_clock_div;
      end else if (wb_adr_i == OFS_CTRL2) begin
        rdat_d[C2_REF_LO +: 2]   = cfg_q.ref_source_sel;
      end else if (wb_adr_i == OFS_RES_HI) begin
        rdat_d[7:0] = res_high(result_q, cfg_q.result_align_sel);
      end else if (wb_adr_i == OFS_RES_LO) begin
        rdat_d[7:0] = res_low(result_q, cfg_q.result_align_sel);
      end else if (wb_adr_i == OFS_STATUS) begin
        rdat_d[IRQ_DONE] = flag_q;
      end else if (wb_adr_i == OFS_MASK) begin
        rdat_d[IRQ_DONE] = mask_q;
      end else if (wb_adr_i == OFS_GIE) begin
        rdat_d[IRQ_DONE] = gie_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // software-written configuration
  always_comb begin
    cfg_d   = cfg_q;
    start_d = start_q;
    mask_d  = mask_q;
    gie_d   = gie_q;
    if (wr_en) begin
      if (wb_adr_i == OFS_CTRL0) begin
        // busy bit position is ignored on write
        start_d                  = wb_dat_i[C0_START];
        cfg_d.converter_power_en = wb_dat_i[C0_PWR];
        cfg_d.result_align_sel   = wb_dat_i[C0_ALIGN];
        cfg_d.ext_channel_sel    = wb_dat_i[C0_CH_LO +: 4];
      end else if (wb_adr_i == OFS_CTRL1) begin
        cfg_d.input_source_sel   = wb_dat_i[C1_SRC_LO +: 4];
        cfg_d.conv_clock_div     = wb_dat_i[C1_DIV_LO +: 3];
      end else if (wb_adr_i == OFS_CTRL2) begin
        cfg_d.ref_source_sel     = wb_dat_i[C2_REF_LO +: 2];
      end else if (wb_adr_i == OFS_MASK) begin
        mask_d = wb_dat_i[IRQ_DONE];
      end else if (wb_adr_i == OFS_GIE) begin
        gie_d  = wb_dat_i[IRQ_DONE];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q.ext_channel_sel    <= RST_CHANNEL;
      cfg_q.result_align_sel   <= 1'b0;
      cfg_q.converter_power_en <= 1'b0;
      cfg_q.input_source_sel   <= RST_SOURCE;
      cfg_q.conv_clock_div     <= RST_DIV;
      cfg_q.ref_source_sel     <= RST_REF;
      start_q <= 1'b0;
      mask_q  <= 1'b0;
      gie_q   <= 1'b0;
    end else begin
      cfg_q   <= cfg_d;
      start_q <= start_d;
      mask_q  <= mask_d;
      gie_q   <= gie_d;
    end
  end

  // start edges are seen one cycle after the write lands
  logic start_prev_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_prev_q <= 1'b0;
    end else begin
      start_prev_q <= start_q;
    end
  end

  assign start_fall = ~start_q & start_prev_q;
  assign tick       = (divcnt_q == div_limit(cfg_q.conv_clock_div));

  // sequencer and successive approximation
  always_comb begin
    state_d  = state_q;
    phase_d  = phase_q;
    divcnt_d = tick ? RST_DIVCNT : 7'(divcnt_q + 7'h01);
    sar_d    = sar_q;
    bit_d    = bit_q;
    result_d = result_q;
    done_evt = 1'b0;
    if (!cfg_q.converter_power_en || start_q) begin
      // power off or start held high: converter held in reset
      state_d  = ST_IDLE;
      phase_d  = RST_PHASE;
      divcnt_d = RST_DIVCNT;
    end else begin
      case (state_q)
        ST_IDLE: begin
          divcnt_d = RST_DIVCNT;
          if (start_fall) begin
            state_d = ST_SAMPLE;
            phase_d = RST_PHASE;
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            phase_d = 4'(phase_q + 4'h1);
            if (phase_q == 4'(SAMPLE_TICKS - 1)) begin
              state_d = ST_CONVERT;
              phase_d = RST_PHASE;
              sar_d   = TRIAL_MSB;
              bit_d   = TRIAL_MSB;
            end
          end
        end
        ST_CONVERT: begin
          if (tick) begin
            // comparator high means input at or above the trial code
            sar_d   = (comp_sync_q ? sar_q : (sar_q & ~bit_q)) | (bit_q >> 1);
            bit_d   = bit_q >> 1;
            phase_d = 4'(phase_q + 4'h1);
            if (phase_q == 4'(CONV_TICKS - 1)) begin
              state_d  = ST_DONE;
              result_d = comp_sync_q ? sar_q : (sar_q & ~bit_q);
            end
          end
        end
        ST_DONE: begin
          state_d  = ST_IDLE;
          done_evt = 1'b1;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q  <= ST_IDLE;
      phase_q  <= RST_PHASE;
      divcnt_q <= RST_DIVCNT;
      sar_q    <= RST_RESULT;
      bit_q    <= RST_RESULT;
      result_q <= RST_RESULT;
    end else begin
      state_q  <= state_d;
      phase_q  <= phase_d;
      divcnt_q <= divcnt_d;
      sar_q    <= sar_d;
      bit_q    <= bit_d;
      result_q <= result_d;
    end
  end

  // completion flag: a set in the same cycle as a clearing write wins
  always_comb begin
    flag_d = flag_q;
    if (wr_en && (wb_adr_i == OFS_STATUS) && !wb_dat_i[IRQ_DONE]) begin
      flag_d = 1'b0;
    end
    if (done_evt) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // analog controls, all quiet while powered down
  acs_analog_s analog_d;
  acs_analog_s analog_q;

  always_comb begin
    analog_d = '0;
    if (cfg_q.converter_power_en) begin
      analog_d.converter_power_en = 1'b1;
      analog_d.sample             = (state_q == ST_SAMPLE);
      analog_d.ext_connect        = (cfg_q.input_source_sel == SRC_EXTERNAL);
      analog_d.ext_channel_sel    = cfg_q.ext_channel_sel;
      analog_d.input_source_sel   = cfg_q.input_source_sel;
      analog_d.ref_source_sel     = cfg_q.ref_source_sel;
      analog_d.trial_code         = (state_q == ST_CONVERT) ? sar_q : RST_RESULT;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_q <= '0;
    end else begin
      analog_q <= analog_d;
    end
  end

  assign analog_o = analog_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign irq_o    = flag_q & mask_q & gie_q;

endmodule
`default_nettype wire

// File: bench/acs_sequencer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_asserts
  import acs_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        comp_i,
  input wire acs_analog_s analog_o,
  input wire logic        irq_o
);
  logic mask_q;
  logic gie_q;
  logic wr_take;
  logic irq_wr;
  // enables are not visible at the ports, so they are mirrored from bus writes
  assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  // only these writes may lower the interrupt line
  assign irq_wr  = wr_take && (wb_adr_i == OFS_STATUS || wb_adr_i == OFS_MASK
                               || wb_adr_i == OFS_GIE);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= 1'b0;
      gie_q  <= 1'b0;
    end else if (wr_take && wb_adr_i == OFS_MASK) begin
      mask_q <= wb_dat_i[IRQ_DONE];
    end else if (wr_take && wb_adr_i == OFS_GIE) begin
      gie_q <= wb_dat_i[IRQ_DONE];
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence req_taken_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence conv_entry_s;
    $past(analog_o.trial_code) == RST_RESULT && analog_o.trial_code != RST_RESULT;
  endsequence

  ack_follows_a: assert property (req_taken_s |=> wb_ack_o)
    else $error("no ack one cycle after a request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  power_quiet_a: assert property (!analog_o.converter_power_en |-> analog_o == '0)
    else $error("analog controls active while powered off");
  ext_cut_a: assert property (analog_o.input_source_sel != SRC_EXTERNAL |-> !analog_o.ext_connect)
    else $error("external input joined with internal source");
  sample_clean_a: assert property (analog_o.sample |-> analog_o.trial_code == RST_RESULT)
    else $error("trial code during sampling");
  conv_entry_a: assert property (conv_entry_s |-> analog_o.trial_code == TRIAL_MSB && $past(analog_o.sample))
    else $error("conversion did not start from sampling at msb");
  irq_gate_a: assert property (irq_o |-> mask_q && gie_q)
    else $error("irq without both enables");
  irq_sticky_a: assert property (irq_o && !irq_wr |=> irq_o)
    else $error("irq dropped without a clearing write");
  ack_has_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
endmodule

bind acs_sequencer acs_sequencer_asserts u_acs_sequencer_asserts (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .comp_i, .analog_o, .irq_o);
`default_nettype wire

// File: bench/acs_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model
  import acs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire acs_analog_s analog_i,
  input  wire logic [11:0] ext_v_i,
  input  wire logic [11:0] int_v_i,
  input  wire logic        slow_i,
  output logic             comp_o
);
  logic [11:0] lvl;
  logic        now_c;
  logic        late_q;
  logic        tog_q = 1'b0;
  assign lvl = analog_i.ext_connect ? ext_v_i : int_v_i;
  // ideal transfer: code step is reference over 4096, full scale gives all ones
  assign now_c = lvl >= analog_i.trial_code;
  always_ff @(posedge clk_i) begin
    late_q <= now_c;
    tog_q  <= !tog_q;
  end
  // unpowered or idle comparator has no meaning, so it wanders every cycle
  assign comp_o = (!analog_i.converter_power_en || analog_i.trial_code == RST_RESULT) ? tog_q
                : (slow_i ? late_q : now_c);
endmodule
`default_nettype wire

// File: bench/adc_conversion_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_test;
  import acs_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'hf;
  logic [3:0]  sel_nx = 4'hf;
  logic [31:0] rdat;
  logic        ack;
  logic        comp;
  logic        irq;
  logic        slow = 1'b0;
  logic [11:0] ext_v = 12'h000;
  logic [11:0] int_v = 12'h000;
  acs_analog_s ana;
  int          bad_count = 0;
  int          check_count = 0;
  int          samp_n = 0;
  int          conv_n = 0;

  acs_sequencer u_acs_sequencer (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .comp_i(comp), .analog_o(ana), .irq_o(irq));
  acs_analog_model u_acs_analog_model (.clk_i, .analog_i(ana), .ext_v_i(ext_v),
    .int_v_i(int_v), .slow_i(slow), .comp_o(comp));

  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (ana.sample) samp_n++;
    if (ana.trial_code != RST_RESULT) conv_n++;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= sel_nx;
    wdat <= {24'h0, d};
    // no local limit: only the watchdog ends a wait for ack
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
  endtask

  function automatic logic [15:0] exp_res(input logic [11:0] r, input logic al);
    return al ? {4'h0, r} : {r, 4'h0};
  endfunction

  task finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    // worst case is a few conversions at the slowest divider, well below this
    #(8 * 60000);
    bad_count++;
    finish_test();
  end

  initial begin
    logic [31:0] q;
    logic [31:0] q2;
    logic [7:0]  c0;
    logic [2:0]  dv;
    logic [1:0]  rf;
    logic [3:0]  src;
    logic [11:0] ev;
    logic [11:0] iv;
    int          n;
    int          s0;
    int          v0;
    void'($urandom(79858));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1, 8'h20, 8'hff, q);
    for (int a = 0; a <= 32; a += 4) begin
      bus(0, 8'(a), 8'h00, q);
      chk(q, 32'h0);
    end
    // launch attempt while unpowered, busy bit written too
    bus(1, OFS_CTRL0, 8'hc0, q);
    bus(1, OFS_CTRL0, 8'h40, q);
    repeat (40) @(posedge clk_i);
    bus(0, OFS_STATUS, 8'h00, q);
    chk(q, 32'h0);
    bus(0, OFS_CTRL0, 8'h00, q);
    chk(q, 32'h0);
    // a write without lane 0 selected is ignored
    sel_nx = 4'he;
    bus(1, OFS_MASK, 8'h01, q);
    sel_nx = 4'hf;
    bus(0, OFS_MASK, 8'h00, q);
    chk(q, 32'h0);
    for (int i = 0; i < 12; i++) begin
      dv = (i < 8) ? 3'(i) : 3'($urandom_range(7, 2));
      src = (i % 3 == 0) ? 4'($urandom_range(15, 1)) : SRC_EXTERNAL;
      ev = (i == 2) ? 12'hfff : (i == 5) ? 12'h000 : 12'($urandom);
      iv = 12'($urandom);
      ext_v <= ev;
      int_v <= iv;
      slow <= dv > 3'h2;
      c0 = {3'b001, 1'($urandom), 4'($urandom)};
      bus(1, OFS_CTRL1, {src, 1'b0, dv}, q);
      rf = 2'($urandom_range(3, 0));
      bus(1, OFS_CTRL2, {6'h0, rf}, q);
      bus(1, OFS_MASK, 8'(i % 2), q);
      bus(1, OFS_GIE, 8'(i / 2 % 2), q);
      bus(1, OFS_CTRL0, c0 | 8'h80, q);
      s0 = samp_n;
      v0 = conv_n;
      bus(1, OFS_CTRL0, c0, q);
      bus(1, OFS_CTRL0, c0 | 8'h40, q);
      bus(0, OFS_CTRL0, 8'h00, q);
      chk(q, {24'h0, c0 | 8'h40});
      n = 0;
      do bus(0, OFS_STATUS, 8'h00, q); while (q !== 32'h1 && n++ < 1000);
      chk(q, 32'h1);
      chk(32'(samp_n - s0), 32'(SAMPLE_TICKS << dv));
      chk(32'(conv_n - v0), 32'(CONV_TICKS << dv));
      chk({31'h0, irq}, 32'(i % 4 == 3));
      chk({20'h0, ana.converter_power_en, ana.ext_connect, ana.ext_channel_sel,
           ana.input_source_sel, ana.ref_source_sel},
          {20'h0, 1'b1, src == SRC_EXTERNAL, c0[3:0], src, rf});
      bus(0, OFS_CTRL0, 8'h00, q);
      chk(q, {24'h0, c0});
      bus(0, OFS_RES_HI, 8'h00, q);
      bus(0, OFS_RES_LO, 8'h00, q2);
      if (dv > 3'h1)
        chk({16'h0, q[7:0], q2[7:0]}, {16'h0, exp_res(src == 0 ? ev : iv, c0[4])});
      bus(1, OFS_STATUS, 8'h01, q);
      bus(0, OFS_STATUS, 8'h00, q);
      chk(q, 32'h1);
      bus(1, OFS_STATUS, 8'h00, q);
      bus(0, OFS_STATUS, 8'h00, q);
      chk(q, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    finish_test();
  end
endmodule
`default_nettype wire
